// File: shared/slc_pkg.sv
// Constants and types of the sensor logging control block
// Summary of operation
// - Drive field: 00 push-pull, 01 pull-up, 10 inverted pull-down, 11 high-z default.
// - Source 00 comparator, 01 command busy, 10 RF field present.
// - Battery check enabled runs a check at each logging event start.
// - Type 000 is 1.5 V, 001 is 3.0 V; new type applies after power-up.
// - Only enabled temperature, battery, external measurements are requested during logging.
// - External irq triggers on falling crossing, rearms only after rising again.
// - Dense mode logs every event, no counter or clock values.
// - Interrupt mode logs every event, 10 bits, clock value and source code.
// - Normal limit mode logs with counter only when any limit condition met.
// - Crossing mode logs with counter only when limit conditions changed.
// - Dense with format 0 stores upper 8 bits, else all 10.
// - Compression maps 10-bit result to 8 bits by leading-bit range.
// - External current select enabled only during external measurement.
// - Limit-exceeded flag set when any of eight limit counts exceeded.
// - Active-wakeup flag set on power-up with wakeup mode and active set.
// - Low-battery flag set when enabled check reports low battery.
// - Conversion error sticky on logging over/underflow, not on demand measurement.
// - Overwrite flag on overwritten record, memory-full flag on dropped record.
// - 12-bit pointer advances on each logging write, stored at logging end.
// - Active bit shows active state; wakeup mode returns straight to active only while the active bit is set.
package slc_pkg;
    localparam logic [1:0] DRV_PUSH     = 2'h0;
    localparam logic [1:0] DRV_PULLUP   = 2'h1;
    localparam logic [1:0] DRV_PULLDN   = 2'h2;
    localparam logic [1:0] DRV_HIZ      = 2'h3;
    localparam logic [1:0] SRC_COMP     = 2'h0;
    localparam logic [1:0] SRC_CMD      = 2'h1;
    localparam logic [1:0] SRC_FIELD    = 2'h2;
    localparam logic [1:0] SRC_FLAGS    = 2'h3;
    localparam logic [1:0] MODE_DENSE   = 2'h0;
    localparam logic [1:0] MODE_IRQ     = 2'h1;
    localparam logic [1:0] MODE_LIMIT   = 2'h2;
    localparam logic [1:0] MODE_CROSS   = 2'h3;
    localparam logic [1:0] IRQSRC_EXT   = 2'h1;
    localparam logic [1:0] IRQSRC_DIN   = 2'h2;
    localparam logic [2:0] BATT_1V5     = 3'h0;
    localparam logic [2:0] BATT_3V0     = 3'h1;
    localparam int         PULSE_HIGH   = 32;
    localparam int         PULSE_PERIOD = 1024;
    // Register offsets
    localparam logic [3:0] REG_OUTCFG   = 4'h0;
    localparam logic [3:0] REG_BATCFG   = 4'h1;
    localparam logic [3:0] REG_LOGCFG   = 4'h2;
    localparam logic [3:0] REG_EXTCFG   = 4'h3;
    localparam logic [3:0] REG_STATUS   = 4'h4;
    localparam logic [3:0] REG_PTRLO    = 4'h5;
    localparam logic [3:0] REG_PTRHI    = 4'h6;
    localparam logic [3:0] REG_LIVE     = 4'h7;
    // Reset values
    localparam logic [7:0] OUTCFG_RST   = 8'h03;
    localparam logic [7:0] BATCFG_RST   = 8'h00;
    localparam logic [7:0] LOGCFG_RST   = 8'h00;
    localparam logic [7:0] EXTCFG_RST   = 8'h00;
    // Status bit positions
    localparam int ST_LIMIT = 0;
    localparam int ST_ACTWK = 1;
    localparam int ST_LOWB  = 2;
    localparam int ST_CERR  = 3;
    localparam int ST_OVWR  = 4;
    localparam int ST_FULL  = 5;
    localparam int ST_ACT   = 6;

    typedef struct packed {
        logic       logged;
        logic [1:0] mode;
        logic       with_counter;
        logic       with_clock;
        logic [1:0] irq_source;
        logic       wide;
        logic [9:0] value;
    } slc_record_type;
endpackage

// File: hdl/slc_top.sv
// Sensor logging configuration, status flags and record formatting
`timescale 1ns/100ps
module slc_top #(
    parameter int PTR_W   = 12,
    parameter int LIMIT_N = 8
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Register port
    input  wire logic [3:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [7:0]                  reg_rdata,
    // Power and controller state
    input  wire logic                   power_up,
    input  wire logic                   wakeup_behaviour_select,
    input  wire logic                   active_state,
    output logic                        wake_to_active,
    // Digital output pin
    input  wire logic                   comparator_out,
    input  wire logic                   command_busy,
    input  wire logic                   rf_field,
    input  wire logic                   slow_oscillator_clock,
    output logic                        dout_o,
    output logic                        dout_oe,
    output logic                        pullup_en,
    // External sensor interrupt
    input  wire logic                   external_sensor_pin,
    output logic [1:0]                  external_irq_threshold,
    output logic                        irq_current_en_o,
    output logic                        ext_irq_event,
    // Logging sequence
    input  wire logic                   log_start,
    input  wire logic                   log_end,
    input  wire logic                   din_irq,
    input  wire logic                   meas_ext_active,
    input  wire logic                   on_demand,
    output logic                        battery_check_req,
    output logic [2:0]                  meas_req,
    output logic [2:0]                  battery_type_active,
    output logic [1:0]                  battery_threshold_select,
    output logic [4:0]                  current_sel_o,
    // Results
    input  wire logic                   result_valid,
    input  wire logic [9:0]             external_result_value,
    input  wire logic                   result_is_ext,
    input  wire logic                   conv_error,
    input  wire logic                   battery_low,
    input  wire logic                   battery_check_done,
    input  wire logic [LIMIT_N-1:0]     limit_cond,
    input  wire logic [LIMIT_N-1:0]     limit_count_over,
    // Memory side
    input  wire logic                   record_written,
    input  wire logic [1:0]             record_bits,
    input  wire logic                   overwritten,
    input  wire logic                   no_space,
    output slc_pkg::slc_record_type     record_o,
    output logic [PTR_W-1:0]            log_write_pointer,
    output logic                        pointer_store
);
    logic [7:0] outcfg_q, batcfg_q, logcfg_q, extcfg_q;
    logic [7:0] flags_q;
    logic [2:0] batt_type_q;
    logic [PTR_W-1:0] ptr_q;
    logic [2:0] pin_sync_q;
    logic       armed_q;
    logic [9:0] osc_cnt_q;
    logic [2:0] osc_sync_q;
    logic [LIMIT_N-1:0] prev_limit_q;
    logic       por_q;

    // Field views
    logic [1:0] output_drive_select, output_source_select, logging_mode_select;
    logic       rtc_oscillator_enable, battery_check_enable, logging_width_select;
    logic       external_compress_enable, external_irq_enable, irq_current_enable;
    logic       temperature_measure_enable, battery_measure_enable;
    logic       external_measure_enable;
    logic [2:0] battery_type_select;
    logic [4:0] external_current_select;
    assign output_drive_select        = outcfg_q[1:0];
    assign output_source_select       = outcfg_q[3:2];
    assign rtc_oscillator_enable      = outcfg_q[4];
    assign battery_check_enable       = batcfg_q[0];
    assign battery_type_select        = batcfg_q[3:1];
    assign temperature_measure_enable = logcfg_q[0];
    assign battery_measure_enable     = logcfg_q[1];
    assign external_measure_enable    = logcfg_q[2];
    assign external_irq_enable        = logcfg_q[3];
    assign logging_mode_select        = logcfg_q[5:4];
    assign logging_width_select       = logcfg_q[6];
    assign external_compress_enable   = logcfg_q[7];
    assign irq_current_enable         = extcfg_q[2];
    assign external_current_select    = extcfg_q[7:3];

    // Configuration registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            outcfg_q <= slc_pkg::OUTCFG_RST;
            batcfg_q <= slc_pkg::BATCFG_RST;
            logcfg_q <= slc_pkg::LOGCFG_RST;
            extcfg_q <= slc_pkg::EXTCFG_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                slc_pkg::REG_OUTCFG: outcfg_q <= {3'h0, reg_wdata[4:0]};
                slc_pkg::REG_BATCFG: batcfg_q <= {2'h0, reg_wdata[5:0]};
                slc_pkg::REG_LOGCFG: logcfg_q <= reg_wdata;
                slc_pkg::REG_EXTCFG: extcfg_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Battery type latched only on power-up, so a rewrite waits for the next one
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            batt_type_q <= slc_pkg::BATT_1V5;
            por_q       <= 1'b0;
        end else begin
            por_q <= power_up;
            if (power_up) begin
                batt_type_q <= battery_type_select;
            end
        end
    end

    // Three-stage synchronisers for pin and slow clock
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_sync_q  <= 3'h7;
            osc_sync_q  <= 3'h0;
        end else begin
            pin_sync_q  <= {pin_sync_q[1:0], external_sensor_pin};
            osc_sync_q  <= {osc_sync_q[1:0], slow_oscillator_clock};
        end
    end

    logic pin_fall, pin_rise, osc_rise;
    assign pin_fall  = pin_sync_q[2] & ~pin_sync_q[1];
    assign pin_rise  = ~pin_sync_q[2] & pin_sync_q[1];
    assign osc_rise  = ~osc_sync_q[2] & osc_sync_q[1];

    // External interrupt, rearmed only by a rising crossing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            armed_q       <= 1'b1;
            ext_irq_event <= 1'b0;
        end else begin
            ext_irq_event <= external_irq_enable & armed_q & pin_fall;
            if (pin_fall) begin
                armed_q <= 1'b0;
            end else if (pin_rise) begin
                armed_q <= 1'b1;
            end
        end
    end

    // Slow pulse counter, 1024 counts per period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_cnt_q <= 10'h000;
        end else if (!rtc_oscillator_enable) begin
            osc_cnt_q <= 10'h000;
        end else if (osc_rise) begin
            osc_cnt_q <= osc_cnt_q + 10'h001;
        end
    end

    logic pulse_high, flag_or, src_level;
    assign pulse_high = osc_cnt_q < 10'(slc_pkg::PULSE_HIGH);
    assign flag_or    = flags_q[slc_pkg::ST_FULL] | flags_q[slc_pkg::ST_CERR]
                      | flags_q[slc_pkg::ST_LOWB] | flags_q[slc_pkg::ST_LIMIT];
    always_comb begin
        case (output_source_select)
            slc_pkg::SRC_COMP:  src_level = comparator_out;
            slc_pkg::SRC_CMD:   src_level = command_busy;
            slc_pkg::SRC_FIELD: src_level = rf_field;
            default: src_level = flag_or & (pulse_high | ~rtc_oscillator_enable);
        endcase
    end

    // Output pin drive
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dout_o    <= 1'b0;
            dout_oe   <= 1'b0;
            pullup_en <= 1'b0;
        end else begin
            case (output_drive_select)
                slc_pkg::DRV_PUSH: begin
                    dout_o    <= src_level;
                    dout_oe   <= 1'b1;
                    pullup_en <= 1'b0;
                end
                slc_pkg::DRV_PULLUP: begin
                    dout_o    <= 1'b0;
                    dout_oe   <= ~src_level;
                    pullup_en <= 1'b1;
                end
                slc_pkg::DRV_PULLDN: begin
                    // Inverted: released, so pulled low, while the source is high
                    dout_o    <= 1'b1;
                    dout_oe   <= ~src_level;
                    pullup_en <= 1'b0;
                end
                default: begin
                    dout_o    <= 1'b0;
                    dout_oe   <= 1'b0;
                    pullup_en <= 1'b0;
                end
            endcase
        end
    end

    // Static analog settings and measurement requests
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            external_irq_threshold   <= 2'h0;
            irq_current_en_o         <= 1'b0;
            current_sel_o            <= 5'h00;
            meas_req                 <= 3'h0;
            battery_check_req        <= 1'b0;
            battery_type_active      <= slc_pkg::BATT_1V5;
            battery_threshold_select <= 2'h0;
            wake_to_active           <= 1'b0;
        end else begin
            external_irq_threshold <= extcfg_q[1:0];
            irq_current_en_o       <= irq_current_enable & external_irq_enable;
            current_sel_o          <= meas_ext_active ? external_current_select : 5'h00;
            meas_req <= log_start ? {external_measure_enable, battery_measure_enable,
                                     temperature_measure_enable} : 3'h0;
            battery_check_req      <= log_start & battery_check_enable;
            battery_type_active    <= batt_type_q;
            // Host keeps this at zero for 1.5 V cells
            battery_threshold_select <= batcfg_q[5:4];
            wake_to_active <= power_up & wakeup_behaviour_select
                            & flags_q[slc_pkg::ST_ACT];
        end
    end

    // Record formatting
    logic [7:0] compressed;
    logic       narrow, compress;
    logic       any_limit, limit_changed, take;
    always_comb begin
        if (external_result_value[9]) begin
            compressed = {2'h3, external_result_value[8:3]};
        end else if (external_result_value[9:8] == 2'h1) begin
            compressed = {2'h2, external_result_value[7:2]};
        end else if (external_result_value[9:7] == 3'h1) begin
            compressed = {2'h1, external_result_value[6:1]};
        end else begin
            compressed = {2'h0, external_result_value[5:0]};
        end
    end
    assign narrow        = (logging_mode_select == slc_pkg::MODE_DENSE)
                         & ~logging_width_select;
    assign compress      = narrow & external_compress_enable & result_is_ext;
    assign any_limit     = |limit_cond;
    assign limit_changed = limit_cond != prev_limit_q;
    always_comb begin
        case (logging_mode_select)
            slc_pkg::MODE_DENSE: take = 1'b1;
            slc_pkg::MODE_IRQ:   take = 1'b1;
            slc_pkg::MODE_LIMIT: take = any_limit;
            default:             take = limit_changed;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            record_o     <= '0;
            prev_limit_q <= '0;
        end else begin
            record_o.logged       <= result_valid & ~on_demand & take;
            record_o.mode         <= logging_mode_select;
            record_o.with_counter <= logging_mode_select[1];
            record_o.with_clock   <= logging_mode_select == slc_pkg::MODE_IRQ;
            record_o.irq_source   <= (logging_mode_select != slc_pkg::MODE_IRQ) ? 2'h0 :
                                     din_irq ? slc_pkg::IRQSRC_DIN : slc_pkg::IRQSRC_EXT;
            record_o.wide         <= ~narrow;
            record_o.value        <= compress ? {2'h0, compressed} :
                                     narrow ? {2'h0, external_result_value[9:2]} :
                                     external_result_value;
            if (result_valid & ~on_demand & take) begin
                prev_limit_q <= limit_cond;
            end
        end
    end

    // Measurement pointer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_q         <= '0;
            pointer_store <= 1'b0;
        end else begin
            if (record_written) begin
                ptr_q <= ptr_q + PTR_W'(record_bits) + PTR_W'(1);
            end
            pointer_store <= log_end;
        end
    end
    assign log_write_pointer = ptr_q;

    // Status flags, bits 5:0 sticky; a set in the clearing cycle wins
    logic [7:0] set_vec, clr_vec;
    always_comb begin
        set_vec = 8'h00;
        set_vec[slc_pkg::ST_LIMIT] = |limit_count_over;
        set_vec[slc_pkg::ST_ACTWK] = por_q & wakeup_behaviour_select
                                   & flags_q[slc_pkg::ST_ACT];
        set_vec[slc_pkg::ST_LOWB]  = battery_check_done & battery_low
                                   & battery_check_enable;
        set_vec[slc_pkg::ST_CERR]  = conv_error & ~on_demand;
        set_vec[slc_pkg::ST_OVWR]  = overwritten;
        set_vec[slc_pkg::ST_FULL]  = no_space;
        clr_vec = (reg_wr && reg_addr == slc_pkg::REG_STATUS) ? reg_wdata : 8'h00;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags_q <= 8'h00;
        end else begin
            flags_q[5:0] <= (flags_q[5:0] & ~clr_vec[5:0]) | set_vec[5:0];
            flags_q[slc_pkg::ST_ACT] <= active_state;
            flags_q[7] <= 1'b0;
        end
    end

    // Read port
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                slc_pkg::REG_OUTCFG: reg_rdata <= outcfg_q;
                slc_pkg::REG_BATCFG: reg_rdata <= batcfg_q;
                slc_pkg::REG_LOGCFG: reg_rdata <= logcfg_q;
                slc_pkg::REG_EXTCFG: reg_rdata <= extcfg_q;
                slc_pkg::REG_STATUS: reg_rdata <= flags_q;
                slc_pkg::REG_PTRLO:  reg_rdata <= ptr_q[7:0];
                slc_pkg::REG_PTRHI:  reg_rdata <= {4'h0, ptr_q[11:8]};
                slc_pkg::REG_LIVE:   reg_rdata <= {5'h00, batt_type_q};
                default:             reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Checks
    property p_hiz_default;
        @(posedge clk) disable iff (!reset_n)
        (output_drive_select == slc_pkg::DRV_HIZ) |=> !dout_oe;
    endproperty
    a_hiz_default: assert property (p_hiz_default) else $error("pin driven in high-z");

    property p_irq_once;
        @(posedge clk) disable iff (!reset_n)
        ext_irq_event |=> !ext_irq_event;
    endproperty
    a_irq_once: assert property (p_irq_once) else $error("repeated irq");

    property p_current;
        @(posedge clk) disable iff (!reset_n)
        !meas_ext_active |=> current_sel_o == 5'h00;
    endproperty
    a_current: assert property (p_current) else $error("current outside measure");

    property p_cerr;
        @(posedge clk) disable iff (!reset_n)
        (conv_error && !on_demand) |=> flags_q[slc_pkg::ST_CERR];
    endproperty
    a_cerr: assert property (p_cerr) else $error("error flag missed");

    property p_full;
        @(posedge clk) disable iff (!reset_n)
        no_space |=> flags_q[slc_pkg::ST_FULL];
    endproperty
    a_full: assert property (p_full) else $error("full flag missed");

    property p_ptr;
        @(posedge clk) disable iff (!reset_n)
        record_written |=> ptr_q == $past(ptr_q) + PTR_W'($past(record_bits)) + PTR_W'(1);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer step wrong");

    property p_battery;
        @(posedge clk) disable iff (!reset_n)
        (log_start && battery_check_enable) |=> battery_check_req;
    endproperty
    a_battery: assert property (p_battery) else $error("no battery check");

    property p_limit;
        @(posedge clk) disable iff (!reset_n)
        (|limit_count_over) |=> flags_q[slc_pkg::ST_LIMIT];
    endproperty
    a_limit: assert property (p_limit) else $error("limit flag missed");

    property p_battery_type_select;
        @(posedge clk) disable iff (!reset_n)
        !power_up |=> $stable(batt_type_q);
    endproperty
    a_battery_type_select: assert property (p_battery_type_select) else $error("type changed early");
endmodule // slc_top

// File: verification/slc_top_tb.sv
// Self-checking testbench of the sensor logging control block
`timescale 1ns/100ps
module slc_top_tb;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  ra = 4'h0;
    logic [7:0]  wd = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [8:0]  pv = 9'h000;
    logic [1:0]  lvl = 2'h0;
    logic [2:0]  src = 3'h0;
    logic [9:0]  rv = 10'h000;
    logic        dmd = 1'b0;
    logic        blow = 1'b0;
    logic [7:0]  lco = 8'h00;
    logic [7:0]  lc = 8'h00;
    logic [1:0]  rb = 2'h3;
    logic [7:0]  rdata;
    logic        dout;
    logic        doe;
    logic        wta;
    logic        bcreq;
    logic        pstore;
    logic [2:0]  mreq;
    logic [2:0]  btyp;
    logic [11:0] ptr;
    logic        pue;
    logic        irq;
    logic [4:0]  csel;
    logic        mext = 1'b0;
    logic        pin = 1'b1;
    logic        osc = 1'b0;
    slc_pkg::slc_record_type rec;
    int          fails = 0;
    int          checks_done = 0;
    logic [9:0]  cin [4] = '{10'h2a5, 10'h16a, 10'h0b3, 10'h04d};
    logic [7:0]  cout [4] = '{8'hd4, 8'h9a, 8'h59, 8'h0d};

    always #12.5 clk = ~clk;

    slc_top slc_top_inst (.clk, .reset_n, .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdata), .power_up(pv[0]), .wakeup_behaviour_select(lvl[0]),
        .active_state(lvl[1]), .wake_to_active(wta), .comparator_out(src[0]),
        .command_busy(src[1]), .rf_field(src[2]), .slow_oscillator_clock(osc),
        .dout_o(dout), .dout_oe(doe), .pullup_en(pue), .external_sensor_pin(pin),
        .external_irq_threshold(), .irq_current_en_o(), .ext_irq_event(irq),
        .log_start(pv[1]), .log_end(pv[8]), .din_irq(1'b0), .meas_ext_active(mext),
        .on_demand(dmd), .battery_check_req(bcreq), .meas_req(mreq),
        .battery_type_active(btyp), .battery_threshold_select(), .current_sel_o(csel),
        .result_valid(pv[3]), .external_result_value(rv), .result_is_ext(1'b1),
        .conv_error(pv[2]), .battery_low(blow), .battery_check_done(pv[7]),
        .limit_cond(lc), .limit_count_over(lco), .record_written(pv[4]), .record_bits(rb),
        .overwritten(pv[5]), .no_space(pv[6]), .record_o(rec), .log_write_pointer(ptr),
        .pointer_store(pstore));

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string m);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk({4'h0, rdata}, {4'h0, e}, m);
    endtask

    // Pulse for one cycle, return just after the edge that sampled it
    task automatic pulse(input int i);
        @(posedge clk);
        pv[i] <= 1'b1;
        @(posedge clk);
        pv[i] <= 1'b0;
        #1;
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #(25 * 4000);
        fails++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1 chk(doe, 1'b0, "oe at reset");
        rchk(slc_pkg::REG_OUTCFG, slc_pkg::OUTCFG_RST, "outcfg reset");
        rchk(4'hf, 8'h00, "unmapped read");
        for (int i = 0; i < 3; i++) begin
            wreg(slc_pkg::REG_OUTCFG, 8'(i << 2));
            src <= 3'(1 << i);
            settle();
            chk({dout, doe}, 2'b11, "source high");
            src <= 3'h0;
            settle();
            chk({dout, doe}, 2'b01, "source low");
        end
        wreg(slc_pkg::REG_OUTCFG, 8'h01);
        src <= 3'h1;
        settle();
        chk({dout, doe, pue}, 3'b001, "pull-up off");
        wreg(slc_pkg::REG_OUTCFG, 8'h02);
        settle();
        chk({dout, doe, pue}, 3'b100, "pull-down off");
        src <= 3'h0;
        settle();
        chk({dout, doe, pue}, 3'b110, "pull-down on");
        wreg(slc_pkg::REG_OUTCFG, 8'h03);
        settle();
        chk(doe, 1'b0, "high impedance");
        $display("test output pin done");
        lvl <= 2'b11;
        wreg(slc_pkg::REG_BATCFG, 8'h03);
        settle();
        chk(btyp, slc_pkg::BATT_1V5, "type before power-up");
        pulse(0);
        chk(wta, 1'b1, "wake to active");
        @(posedge clk);
        #1 chk(btyp, slc_pkg::BATT_3V0, "type after power-up");
        wreg(slc_pkg::REG_LOGCFG, 8'h05);
        pulse(1);
        chk({bcreq, mreq}, 4'b1101, "measure requests");
        blow <= 1'b1;
        pulse(7);
        dmd <= 1'b1;
        pulse(2);
        rchk(slc_pkg::REG_STATUS, 8'h46, "on-demand error ignored");
        dmd <= 1'b0;
        pulse(2);
        pulse(5);
        pulse(6);
        lco <= 8'h80;
        @(posedge clk);
        lco <= 8'h00;
        rchk(slc_pkg::REG_STATUS, 8'h7f, "all flags");
        wreg(slc_pkg::REG_OUTCFG, 8'h0c);
        settle();
        chk(dout, 1'b1, "flag source");
        wreg(slc_pkg::REG_STATUS, 8'h3f);
        settle();
        chk(dout, 1'b0, "flag source cleared");
        rchk(slc_pkg::REG_STATUS, 8'h40, "flags cleared");
        $display("test status done");
        wreg(slc_pkg::REG_LOGCFG, 8'h80);
        for (int i = 0; i < 4; i++) begin
            rv <= cin[i];
            pulse(3);
            chk({rec.logged, rec.with_counter, rec.with_clock, rec.wide, rec.value[7:0]},
                {4'b1000, cout[i]}, "compress");
        end
        wreg(slc_pkg::REG_LOGCFG, 8'h00);
        rv <= 10'h2a5;
        pulse(3);
        chk({rec.wide, rec.value}, 11'h0a9, "narrow");
        wreg(slc_pkg::REG_LOGCFG, 8'h90);
        rv <= 10'h0ff;
        pulse(3);
        chk({rec.with_clock, rec.wide, rec.value}, 12'hcff, "irq mode record");
        chk(rec.irq_source, slc_pkg::IRQSRC_EXT, "irq source");
        wreg(slc_pkg::REG_LOGCFG, 8'h20);
        pulse(3);
        chk(rec.logged, 1'b0, "limit mode idle");
        lc <= 8'h01;
        pulse(3);
        chk({rec.logged, rec.with_counter}, 2'b11, "limit mode logs");
        wreg(slc_pkg::REG_LOGCFG, 8'h30);
        pulse(3);
        chk(rec.logged, 1'b0, "crossing idle");
        lc <= 8'h03;
        pulse(3);
        chk({rec.logged, rec.with_counter}, 2'b11, "crossing logs");
        $display("test records done");
        repeat (3) pulse(4);
        chk(ptr, 12'h00c, "pointer");
        pulse(8);
        chk(pstore, 1'b1, "pointer store");
        rchk(slc_pkg::REG_PTRLO, 8'h0c, "pointer low");
        $display("test pointer done");
        wreg(slc_pkg::REG_LOGCFG, 8'h08);
        pin <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(irq, 1'b1, "irq on fall");
        @(posedge clk);
        #1 chk(irq, 1'b0, "irq once");
        wreg(slc_pkg::REG_EXTCFG, 8'ha8);
        mext <= 1'b1;
        @(posedge clk);
        #1 chk(csel, 5'h15, "current on");
        mext <= 1'b0;
        @(posedge clk);
        #1 chk(csel, 5'h00, "current off");
        pulse(6);
        wreg(slc_pkg::REG_OUTCFG, 8'h1c);
        settle();
        chk(dout, 1'b1, "pulse high");
        repeat (slc_pkg::PULSE_HIGH) begin
            osc <= 1'b1;
            repeat (2) @(posedge clk);
            osc <= 1'b0;
            repeat (2) @(posedge clk);
        end
        settle();
        chk(dout, 1'b0, "pulse low");
        $display("test irq and pulse done");
        close_out();
    end
endmodule // slc_top_tb
